// ==== cabs_alu.sv ====
// Execute unit for add, and, bit set/clear and bit-test-skip instructions
`timescale 1ns/1ns
// Functional notes
// RULE1: Add-literal sums work and the literal into work and updates carry, digit carry and zero.
// RULE2: Add-file sums work and the file register into work (dest 0) or the file (dest 1), updating all three flags.
// RULE3: And-file ANDs work with the file register, routed by dest, changing only zero.
// RULE4: And-literal ANDs work with the literal into work, changing only zero.
// RULE5: Bit-clear forces the selected bit of the file register low, flags untouched.
// RULE6: Bit-set forces the selected bit of the file register high, flags untouched.
// RULE7: Skip-if-clear replaces the next instruction with a no-operation when the tested bit is 0.
// RULE8: Skip-if-set replaces the next instruction with a no-operation when the tested bit is 1.
// RULE9: A read-modify-write of a port register takes its operand from the pin levels, not the latch.
// RULE10: A true conditional test costs a second cycle run as a no-operation.
// RULE11: Zero marks an all-zero result; carry is carry out of bit 7, digit carry out of bit 3.
module cabs_alu (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // Instruction issue, one per enabled cycle
  input wire logic I_EXEC_EN,
  input wire cabs_pkg::cabs_instr_t I_INSTR,
  // File register read data and port qualification
  input wire logic [7:0] I_FILE_RDATA,
  input wire logic I_FILE_IS_PORT,
  input wire logic [7:0] I_PORT_PINS,
  // File register write back
  output logic O_FILE_WE,
  output logic [6:0] O_FILE_WADDR,
  output logic [7:0] O_FILE_WDATA,
  // Core state
  output logic [7:0] O_WORK,
  output cabs_pkg::cabs_flags_t O_FLAGS,
  output logic O_SKIP,
  output logic O_NOP_CYCLE
);

  // ******************************
  // Operand selection
  // ******************************
  logic [7:0] work;
  cabs_pkg::cabs_flags_t flags;
  logic skip_pending;
  logic nop_cycle;
  logic [7:0] pins_s1;
  logic [7:0] pins_s2;

  // RULE9: pins for port rmw
  wire [7:0] file_operand = I_FILE_IS_PORT ? pins_s2 : I_FILE_RDATA;
  wire cabs_pkg::cabs_op_t op = I_INSTR.op;
  // RULE10: squashed slot executes nothing
  wire live = I_EXEC_EN && !skip_pending;

  wire is_addl = op == cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK;
  wire is_addf = op == cabs_pkg::CABS_OP_ADD_WORK_AND_FILE;
  wire is_andl = op == cabs_pkg::CABS_OP_AND_LITERAL_WITH_WORK;
  wire is_andf = op == cabs_pkg::CABS_OP_AND_WORK_WITH_FILE;
  wire is_bclr = op == cabs_pkg::CABS_OP_BIT_CLEAR_FILE;
  wire is_bset = op == cabs_pkg::CABS_OP_BIT_SET_FILE;
  wire is_tclr = op == cabs_pkg::CABS_OP_SKIP_IF_BIT_CLEAR;
  wire is_tset = op == cabs_pkg::CABS_OP_SKIP_IF_BIT_SET;

  wire [7:0] b_operand = (is_addl || is_andl) ? I_INSTR.literal : file_operand;

  // ******************************
  // Arithmetic and logic
  // ******************************
  // RULE1: add with carries
  // RULE2: add file operand
  // RULE11: carry out positions
  // Two chained nibble adders, so the digit carry is a real adder output
  logic [3:0] sum_low;
  logic [3:0] sum_high;
  logic carry_low;
  logic carry_high;
  cabs_nibble_add #(
    .W(cabs_pkg::DIGIT_MSB + 1)
  ) add_low (
    .i_a(work[cabs_pkg::DIGIT_MSB:0]),
    .i_b(b_operand[cabs_pkg::DIGIT_MSB:0]),
    .i_carry(1'b0),
    .o_sum(sum_low),
    .o_carry(carry_low)
  );
  cabs_nibble_add #(
    .W(cabs_pkg::DATA_W - cabs_pkg::DIGIT_MSB - 1)
  ) add_high (
    .i_a(work[7:cabs_pkg::DIGIT_MSB + 1]),
    .i_b(b_operand[7:cabs_pkg::DIGIT_MSB + 1]),
    .i_carry(carry_low),
    .o_sum(sum_high),
    .o_carry(carry_high)
  );
  wire [7:0] sum_res = {sum_high, sum_low};
  // RULE3: bitwise and
  // RULE4: and with literal
  wire [7:0] and_res = work & b_operand;
  wire is_add = is_addl || is_addf;
  wire [7:0] alu_res = is_add ? sum_res : and_res;
  // RULE11: zero detect
  wire res_zero = alu_res == 8'h00;

  // RULE5: clear selected bit
  // RULE6: set selected bit
  wire [7:0] bit_mask = 8'h01 << I_INSTR.bit_sel;
  wire [7:0] bit_res = is_bset ? (file_operand | bit_mask) : (file_operand & ~bit_mask);
  wire tested_bit = |(file_operand & bit_mask);

  // ******************************
  // Destination routing
  // ******************************
  wire alu_op = is_add || is_andl || is_andf;
  wire to_file_alu = (is_addf || is_andf) && I_INSTR.dest_file;
  wire next_file_we = live && (to_file_alu || is_bclr || is_bset);
  wire [7:0] next_file_wdata = (is_bclr || is_bset) ? bit_res : alu_res;
  wire work_we = live && alu_op && !to_file_alu;

  cabs_pkg::cabs_flags_t next_flags;
  always_comb begin
    next_flags = flags;
    if (live && alu_op) begin
      next_flags.zero = res_zero;
      if (is_add) begin
        next_flags.carry = carry_high;
        next_flags.digit_carry_flag = carry_low;
      end
    end
  end

  // RULE7: skip on clear bit
  // RULE8: skip on set bit
  wire next_skip = live && ((is_tclr && !tested_bit) || (is_tset && tested_bit));

  // ******************************
  // State registers
  // ******************************
  // Pins are asynchronous: two flops before anything reads them
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pins_s1 <= 8'h00;
      pins_s2 <= 8'h00;
    end else begin
      pins_s1 <= I_PORT_PINS;
      pins_s2 <= pins_s1;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      work <= cabs_pkg::WORK_RESET;
    end else if (work_we) begin
      work <= alu_res;
    end
  end

  // RULE11: flags follow the last ALU result
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      flags <= cabs_pkg::cabs_flags_t'(cabs_pkg::FLAGS_RESET);
    end else begin
      flags <= next_flags;
    end
  end

  // Address follows every issue; it only matters while the write strobe is high
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_FILE_WE <= 1'b0;
      O_FILE_WADDR <= 7'h00;
      O_FILE_WDATA <= cabs_pkg::FILE_RESET;
    end else begin
      O_FILE_WE <= next_file_we;
      O_FILE_WADDR <= I_INSTR.file_addr;
      O_FILE_WDATA <= next_file_wdata;
    end
  end

  // RULE10: second cycle as nop
  // A squashed slot stays pending until the sequencer issues into it
  wire next_nop = I_EXEC_EN && skip_pending;

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      skip_pending <= 1'b0;
    end else if (I_EXEC_EN) begin
      skip_pending <= next_skip;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      nop_cycle <= 1'b0;
    end else begin
      nop_cycle <= next_nop;
    end
  end

  assign O_WORK = work;
  assign O_FLAGS = flags;
  assign O_SKIP = skip_pending;
  assign O_NOP_CYCLE = nop_cycle;

endmodule // cabs_alu

// ******************************
// Nibble adder with carry chain
// ******************************
module cabs_nibble_add #(
  parameter int W = 4
) (
  // Operands
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  input wire logic i_carry,
  // Result
  output logic [W-1:0] o_sum,
  output logic o_carry
);

  wire [W:0] total = {1'b0, i_a} + {1'b0, i_b} + {{W{1'b0}}, i_carry};

  assign o_sum = total[W-1:0];
  assign o_carry = total[W];

endmodule // cabs_nibble_add

// ==== cabs_alu_chk.sv ====
// Assertion checker for the cabs_alu execute block
`timescale 1ns/1ns
module cabs_alu_chk (
  // Inputs
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_EXEC_EN,
  input wire cabs_pkg::cabs_instr_t I_INSTR,
  input wire logic [7:0] I_FILE_RDATA,
  input wire logic I_FILE_IS_PORT,
  // Outputs
  input wire logic O_FILE_WE,
  input wire logic [7:0] O_FILE_WDATA,
  input wire logic [7:0] O_WORK,
  input wire cabs_pkg::cabs_flags_t O_FLAGS,
  input wire logic O_SKIP,
  input wire logic O_NOP_CYCLE
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // Port operands arrive late through the synchroniser, so they are left out
  wire tk = I_EXEC_EN && !O_SKIP && !I_FILE_IS_PORT;
  wire cabs_pkg::cabs_op_t op = I_INSTR.op;
  wire lit = op == cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK;
  wire ltand = op == cabs_pkg::CABS_OP_AND_LITERAL_WITH_WORK;
  wire [7:0] opd = (lit || ltand) ? I_INSTR.literal : I_FILE_RDATA;
  wire [8:0] sum = O_WORK + opd;
  wire [4:0] low = O_WORK[3:0] + opd[3:0];
  wire [2:0] addf = {sum[8], low[4], sum[7:0] == 8'h00};
  wire [7:0] andv = O_WORK & opd;
  wire andz = andv == 8'h00;
  wire [7:0] msk = 8'h01 << I_INSTR.bit_sel;
  wire bt = |(I_FILE_RDATA & msk);
  wire hit = (op == cabs_pkg::CABS_OP_SKIP_IF_BIT_SET) ? bt : (op == cabs_pkg::CABS_OP_SKIP_IF_BIT_CLEAR) && !bt;
  sequence skip_taken;
    tk && hit ##1 I_EXEC_EN;
  endsequence
  add_lit_a: assert property (tk && lit |=>
    O_WORK == $past(sum[7:0]) && O_FLAGS == $past(addf)) else $error("add literal wrong");
  add_file_a: assert property (tk && op == cabs_pkg::CABS_OP_ADD_WORK_AND_FILE && I_INSTR.dest_file |=>
    O_FILE_WE && O_FILE_WDATA == $past(sum[7:0]) && O_FLAGS == $past(addf)) else $error("add file wrong");
  and_lit_a: assert property (tk && ltand |=>
    O_WORK == $past(andv) && O_FLAGS.zero == $past(andz) && $stable(O_FLAGS.carry)) else $error("and literal wrong");
  and_file_a: assert property (tk && op == cabs_pkg::CABS_OP_AND_WORK_WITH_FILE && !I_INSTR.dest_file |=>
    !O_FILE_WE && O_WORK == $past(andv) && $stable(O_FLAGS.digit_carry_flag)) else $error("and file wrong");
  bit_clr_a: assert property (tk && op == cabs_pkg::CABS_OP_BIT_CLEAR_FILE |=>
    O_FILE_WE && O_FILE_WDATA == ($past(I_FILE_RDATA) & ~$past(msk)) && $stable(O_FLAGS)) else $error("bit clear wrong");
  bit_set_a: assert property (tk && op == cabs_pkg::CABS_OP_BIT_SET_FILE |=>
    O_FILE_WE && O_FILE_WDATA == ($past(I_FILE_RDATA) | $past(msk)) && $stable(O_FLAGS)) else $error("bit set wrong");
  skip_nop_a: assert property (skip_taken |-> O_SKIP ##1 O_NOP_CYCLE)
    else $error("skip slot missing");
  drop_slot_a: assert property (O_SKIP && I_EXEC_EN |=> !O_FILE_WE && !O_SKIP && $stable(O_WORK))
    else $error("discarded slot acted");
endmodule // cabs_alu_chk

bind cabs_alu cabs_alu_chk chk (
  .I_REF_CLK(I_REF_CLK),
  .I_RESET(I_RESET),
  .I_EXEC_EN(I_EXEC_EN),
  .I_INSTR(I_INSTR),
  .I_FILE_RDATA(I_FILE_RDATA),
  .I_FILE_IS_PORT(I_FILE_IS_PORT),
  .O_FILE_WE(O_FILE_WE),
  .O_FILE_WDATA(O_FILE_WDATA),
  .O_WORK(O_WORK),
  .O_FLAGS(O_FLAGS),
  .O_SKIP(O_SKIP),
  .O_NOP_CYCLE(O_NOP_CYCLE)
);

// ==== cabs_alu_test.sv ====
// Self-checking bench for cabs_alu
`timescale 1ns/1ns
module cabs_alu_test;
  logic I_REF_CLK = 0, I_RESET = 1, I_EXEC_EN = 0, I_FILE_IS_PORT = 0;
  cabs_pkg::cabs_instr_t I_INSTR = '0;
  logic [7:0] I_FILE_RDATA = 0, I_PORT_PINS = 8'h01;
  logic O_FILE_WE, O_SKIP, O_NOP_CYCLE;
  logic [6:0] O_FILE_WADDR;
  logic [7:0] O_WORK, O_FILE_WDATA;
  logic [6:0] addr = 7'h05;
  cabs_pkg::cabs_flags_t O_FLAGS;
  int failures = 0, tests_run = 0;
  cabs_alu uut (
    .I_REF_CLK(I_REF_CLK),
    .I_RESET(I_RESET),
    .I_EXEC_EN(I_EXEC_EN),
    .I_INSTR(I_INSTR),
    .I_FILE_RDATA(I_FILE_RDATA),
    .I_FILE_IS_PORT(I_FILE_IS_PORT),
    .I_PORT_PINS(I_PORT_PINS),
    .O_FILE_WE(O_FILE_WE),
    .O_FILE_WADDR(O_FILE_WADDR),
    .O_FILE_WDATA(O_FILE_WDATA),
    .O_WORK(O_WORK),
    .O_FLAGS(O_FLAGS),
    .O_SKIP(O_SKIP),
    .O_NOP_CYCLE(O_NOP_CYCLE)
  );
  initial forever #5 I_REF_CLK = ~I_REF_CLK;
  task chk(logic [23:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // Result packed as skip/we, flags, work, written byte
  task ex(cabs_pkg::cabs_op_t op, logic d, logic [2:0] b, logic [7:0] k, rd, logic [23:0] e);
    I_EXEC_EN = 1;
    I_INSTR = '{op, addr, d, b, k};
    I_FILE_RDATA = rd;
    @(negedge I_REF_CLK);
    chk({O_SKIP, O_FILE_WE, 3'b000, O_FLAGS, O_WORK, O_FILE_WE ? O_FILE_WDATA : 8'h00}, e);
  endtask
  task s_add;
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'hFF, 0, 24'h00_FF00);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'h01, 0, 24'h07_0000);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'h88, 0, 24'h00_8800);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'h08, 0, 24'h02_9000);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'h80, 0, 24'h04_1000);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'hF0, 0, 24'h05_0000);
    ex(cabs_pkg::CABS_OP_ADD_WORK_AND_FILE, 0, 0, 0, 8'h88, 24'h00_8800);
    ex(cabs_pkg::CABS_OP_ADD_WORK_AND_FILE, 1, 0, 0, 8'h78, 24'h47_8800);
    chk(O_FILE_WADDR, 7'h05);
  endtask
  task s_and;
    ex(cabs_pkg::CABS_OP_AND_LITERAL_WITH_WORK, 0, 0, 8'h0F, 0, 24'h06_0800);
    ex(cabs_pkg::CABS_OP_AND_WORK_WITH_FILE, 1, 0, 0, 8'hF0, 24'h47_0800);
    ex(cabs_pkg::CABS_OP_AND_WORK_WITH_FILE, 0, 0, 0, 8'h0C, 24'h06_0800);
  endtask
  task s_bit;
    for (int b = 0; b < 8; b++) begin
      addr = {4'h2, b[2:0]};
      ex(cabs_pkg::CABS_OP_BIT_CLEAR_FILE, 0, b, 0, 8'hFF, {16'h4608, 8'hFF ^ (8'h01 << b)});
      chk(O_FILE_WADDR, {4'h2, b[2:0]});
      ex(cabs_pkg::CABS_OP_BIT_SET_FILE, 0, b, 0, 8'h00, {16'h4608, 8'h01 << b});
    end
    // Latch reads 00 but the pins read 01
    I_FILE_IS_PORT = 1;
    ex(cabs_pkg::CABS_OP_BIT_SET_FILE, 0, 1, 0, 8'h00, 24'h46_0803);
    I_FILE_IS_PORT = 0;
  endtask
  task s_skip;
    ex(cabs_pkg::CABS_OP_SKIP_IF_BIT_CLEAR, 0, 3, 0, 8'hF7, 24'h86_0800);
    ex(cabs_pkg::CABS_OP_ADD_LITERAL_TO_WORK, 0, 0, 8'h01, 0, 24'h06_0800);
    chk(O_NOP_CYCLE, 1);
    ex(cabs_pkg::CABS_OP_SKIP_IF_BIT_SET, 0, 7, 0, 8'h80, 24'h86_0800);
    ex(cabs_pkg::CABS_OP_BIT_SET_FILE, 0, 0, 0, 8'h00, 24'h06_0800);
    ex(cabs_pkg::CABS_OP_SKIP_IF_BIT_SET, 0, 7, 0, 8'h7F, 24'h06_0800);
    chk(O_NOP_CYCLE, 0);
    ex(cabs_pkg::CABS_OP_SKIP_IF_BIT_CLEAR, 0, 0, 0, 8'h01, 24'h06_0800);
  endtask
  task results;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge I_REF_CLK);
    I_RESET = 0;
    s_add;
    s_and;
    s_bit;
    s_skip;
    results;
  end
endmodule // cabs_alu_test

// ==== cabs_pkg.sv ====
// Shared types and constants for the ALU and bit-skip execute block
package cabs_pkg;

  // ******************************
  // Widths and reset values
  // ******************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int DIGIT_MSB = 3;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;

  // ******************************
  // Operation select
  // ******************************
  typedef enum logic [3:0] {
    CABS_OP_NONE,
    CABS_OP_ADD_LITERAL_TO_WORK,
    CABS_OP_ADD_WORK_AND_FILE,
    CABS_OP_AND_LITERAL_WITH_WORK,
    CABS_OP_AND_WORK_WITH_FILE,
    CABS_OP_BIT_CLEAR_FILE,
    CABS_OP_BIT_SET_FILE,
    CABS_OP_SKIP_IF_BIT_CLEAR,
    CABS_OP_SKIP_IF_BIT_SET
  } cabs_op_t;

  // Decoded instruction fields
  typedef struct packed {
    cabs_op_t op;
    logic [6:0] file_addr;
    logic dest_file;
    logic [2:0] bit_sel;
    logic [7:0] literal;
  } cabs_instr_t;

  // Status flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } cabs_flags_t;

endpackage
